// file: inc/gpb_pkg.sv
// Constants, types and helpers for the GPIO bank pin configuration block
package gpb_pkg;

	localparam int GPB_PINS = 8;
	localparam int GPB_DATA_W = 32;
	localparam int GPB_REG_W = 8;

	// Register indices; byte address is four times the index
	localparam logic [7:0] GPB_IDX_CFG0 = 8'h23;
	localparam logic [7:0] GPB_IDX_CFG1 = 8'h24;
	localparam logic [7:0] GPB_IDX_CFG2 = 8'h25;
	localparam logic [7:0] GPB_IDX_CFG3 = 8'h26;
	localparam logic [7:0] GPB_IDX_CFG4 = 8'h27;
	localparam logic [7:0] GPB_IDX_CFG5 = 8'h28;
	localparam logic [7:0] GPB_IDX_CFG6 = 8'h29;
	localparam logic [7:0] GPB_IDX_CFG7 = 8'h2a;
	localparam logic [7:0] GPB_IDX_DOUT = 8'h40;
	localparam logic [7:0] GPB_IDX_LEVEL = 8'h41;

	// Field positions inside a pin register
	localparam int GPB_DIR_BIT = 0;
	localparam int GPB_POL_BIT = 1;
	localparam int GPB_ALT_BIT = 2;
	localparam int GPB_ODR_BIT = 7;
	localparam logic [7:0] GPB_CFG_MASK = 8'h87;

	// Values after reset
	localparam logic [7:0] GPB_CFG_RST = 8'h01;
	localparam logic [7:0] GPB_DOUT_RST = 8'h00;

	// Bus answers
	localparam logic [1:0] GPB_RESP_OKAY = 2'h0;
	localparam logic [1:0] GPB_RESP_SLVERR = 2'h2;

	typedef enum logic [0:0] {
		GPB_WR_COLLECT = 1'b0,
		GPB_WR_RESP = 1'b1
	} gpb_wr_t;

	typedef enum logic [0:0] {
		GPB_RD_IDLE = 1'b0,
		GPB_RD_RESP = 1'b1
	} gpb_rd_t;

	// Word index of a byte address, or all ones when misaligned or at 400h and above
	function automatic logic [7:0] gpb_index(input logic [11:0] addr);
		logic [7:0] idx;
		idx = 8'hff;
		if (addr[1:0] == 2'h0 && addr[11:10] == 2'h0) begin
			idx = addr[9:2];
		end
		return idx;
	endfunction

	// Pin register hit for a word index
	function automatic logic gpb_is_cfg(input logic [7:0] idx);
		return idx >= GPB_IDX_CFG0 && idx <= GPB_IDX_CFG7;
	endfunction

endpackage

// file: logic/gpb_pin.sv
// One pad of the bank: synchroniser, polarity and output driver
`timescale 1ns/1ps
module gpb_pin (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Pin configuration
	input wire logic [7:0] cfg,
	// Values from the bank and the game-port logic
	input wire logic gpio_out,
	input wire logic alt_drive,
	input wire logic alt_out,
	// Pad
	input wire logic pad_in,
	output logic pad_out,
	output logic pad_oe_n,
	// Pad level as seen by the internal logic
	output logic level
);
	import gpb_pkg::*;

	logic meta_q, meta_d;
	logic sync_q, sync_d;
	logic level_q, level_d;
	logic out_q, out_d;
	logic oe_n_q, oe_n_d;
	logic drive;
	logic value;

	always_comb begin
		meta_d = pad_in;
		sync_d = meta_q;
		// Inversion sits between pad and logic
		level_d = sync_q ^ cfg[GPB_POL_BIT];
		// Alternate function takes over drive
		if (cfg[GPB_ALT_BIT]) begin
			drive = alt_drive;
			value = alt_out ^ cfg[GPB_POL_BIT];
		end else begin
			drive = ~cfg[GPB_DIR_BIT];
			value = gpio_out ^ cfg[GPB_POL_BIT];
		end
		if (cfg[GPB_ODR_BIT]) begin
			out_d = 1'b0;
			oe_n_d = ~(drive & ~value);
		end else begin
			out_d = value;
			oe_n_d = ~drive;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			level_q <= 1'b0;
			out_q <= 1'b0;
			oe_n_q <= 1'b1;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			level_q <= level_d;
			out_q <= out_d;
			oe_n_q <= oe_n_d;
		end
	end

	assign pad_out = out_q;
	assign pad_oe_n = oe_n_q;
	assign level = level_q;

endmodule

// file: logic/gpb_bank.sv
// Eight-pin GPIO bank with game-port alternate functions and AXI4-Lite regs
//
// Function
// - Bit 0 set means input, clear drives
// - Bit 1 inverts between pad and logic
// - Bit 2 selects game-port alternate function
// - Pins 0-3 carry the four joystick buttons
// - Pins 4-7 carry the four RC axes
// - Bit 7 selects open-drain, else push-pull
// - Pin registers reset to 0x01
// - Pin registers at 23h..2Ah, read/write
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module gpb_bank
	import gpb_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// AXI4-Lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	// AXI4-Lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	// AXI4-Lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Pads
	input wire logic [gpb_pkg::GPB_PINS-1:0] pad_in,
	output logic [gpb_pkg::GPB_PINS-1:0] pad_out,
	output logic [gpb_pkg::GPB_PINS-1:0] pad_oe_n,
	// Game-port buttons, idle high when not routed
	output logic stick_one_button_one,
	output logic stick_one_button_two,
	output logic stick_two_button_one,
	output logic stick_two_button_two,
	// Game-port RC axes, idle high when not routed
	output logic stick_one_x_axis_rc,
	output logic stick_one_y_axis_rc,
	output logic stick_two_x_axis_rc,
	output logic stick_two_y_axis_rc,
	// Axis discharge requests from game-port timing, order x1 y1 x2 y2
	input wire logic [3:0] axis_discharge
);
	import gpb_pkg::*;

	// Pin configuration and data
	logic [7:0] cfg_q [GPB_PINS];
	logic [7:0] cfg_d [GPB_PINS];
	logic [7:0] dout_q, dout_d;
	logic [GPB_PINS-1:0] level;

	// Write channel state
	gpb_wr_t wr_q, wr_d;
	logic aw_have_q, aw_have_d;
	logic w_have_q, w_have_d;
	logic [ADDR_W-1:0] waddr_q, waddr_d;
	logic [7:0] wbyte_q, wbyte_d;
	logic wen_q, wen_d;
	logic [1:0] bresp_q, bresp_d;

	// Read channel state
	gpb_rd_t rd_q, rd_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;

	// Game-port side registers
	logic [3:0] button_q, button_d;
	logic [3:0] axis_q, axis_d;

	logic [7:0] widx;
	logic [7:0] ridx;
	logic [11:0] waddr_w;
	logic [11:0] raddr_w;
	logic do_write;

	// Widen or cut the bus address to the decoder's 12 bits
	assign waddr_w = 12'(waddr_q);
	assign raddr_w = 12'(s_axi_araddr);
	assign widx = gpb_index(waddr_w);
	assign ridx = gpb_index(raddr_w);

	// Address and data may arrive in either order; answer follows both
	assign s_axi_awready = (wr_q == GPB_WR_COLLECT) && !aw_have_q;
	assign s_axi_wready = (wr_q == GPB_WR_COLLECT) && !w_have_q;
	assign do_write = (wr_q == GPB_WR_COLLECT) && aw_have_q && w_have_q;

	always_comb begin
		wr_d = wr_q;
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		waddr_d = waddr_q;
		wbyte_d = wbyte_q;
		wen_d = wen_q;
		bresp_d = bresp_q;
		unique case (wr_q)
			GPB_WR_COLLECT: begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_have_d = 1'b1;
					waddr_d = s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_have_d = 1'b1;
					wbyte_d = s_axi_wdata[7:0];
					wen_d = s_axi_wstrb[0];
				end
				if (do_write) begin
					aw_have_d = 1'b0;
					w_have_d = 1'b0;
					wr_d = GPB_WR_RESP;
					if (gpb_is_cfg(widx) || widx == GPB_IDX_DOUT ||
						widx == GPB_IDX_LEVEL) begin
						bresp_d = GPB_RESP_OKAY;
					end else begin
						bresp_d = GPB_RESP_SLVERR;
					end
				end
			end
			GPB_WR_RESP: begin
				if (s_axi_bready) begin
					wr_d = GPB_WR_COLLECT;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_q <= GPB_WR_COLLECT;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			waddr_q <= '0;
			wbyte_q <= 8'h00;
			wen_q <= 1'b0;
			bresp_q <= GPB_RESP_OKAY;
		end else begin
			wr_q <= wr_d;
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			waddr_q <= waddr_d;
			wbyte_q <= wbyte_d;
			wen_q <= wen_d;
			bresp_q <= bresp_d;
		end
	end

	assign s_axi_bvalid = (wr_q == GPB_WR_RESP);
	assign s_axi_bresp = bresp_q;

	// Register storage; only the low byte lane carries data
	always_comb begin
		for (int i = 0; i < GPB_PINS; i++) begin
			cfg_d[i] = cfg_q[i];
		end
		dout_d = dout_q;
		if (do_write && wen_q) begin
			if (gpb_is_cfg(widx)) begin
				// Reserved bits never stored, so they read zero
				cfg_d[3'(widx - GPB_IDX_CFG0)] =
					wbyte_q & GPB_CFG_MASK;
			end else if (widx == GPB_IDX_DOUT) begin
				dout_d = wbyte_q;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < GPB_PINS; i++) begin
				cfg_q[i] <= GPB_CFG_RST;
			end
			dout_q <= GPB_DOUT_RST;
		end else begin
			for (int i = 0; i < GPB_PINS; i++) begin
				cfg_q[i] <= cfg_d[i];
			end
			dout_q <= dout_d;
		end
	end

	// Read channel answers one cycle after the address is taken
	// Data is captured when the address is taken, so a level read is a
	// snapshot; later pad changes need a fresh read
	assign s_axi_arready = (rd_q == GPB_RD_IDLE);

	always_comb begin
		rd_d = rd_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		unique case (rd_q)
			GPB_RD_IDLE: begin
				if (s_axi_arvalid) begin
					rd_d = GPB_RD_RESP;
					rdata_d = 32'h0000_0000;
					rresp_d = GPB_RESP_OKAY;
					if (gpb_is_cfg(ridx)) begin
						rdata_d[7:0] =
							cfg_q[3'(ridx - GPB_IDX_CFG0)];
					end else if (ridx == GPB_IDX_DOUT) begin
						rdata_d[7:0] = dout_q;
					end else if (ridx == GPB_IDX_LEVEL) begin
						rdata_d[7:0] = level;
					end else begin
						rresp_d = GPB_RESP_SLVERR;
					end
				end
			end
			GPB_RD_RESP: begin
				if (s_axi_rready) begin
					rd_d = GPB_RD_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_q <= GPB_RD_IDLE;
			rdata_q <= 32'h0000_0000;
			rresp_q <= GPB_RESP_OKAY;
		end else begin
			rd_q <= rd_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	assign s_axi_rvalid = (rd_q == GPB_RD_RESP);
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// Pads; buttons never drive, axes drive low to discharge the RC while bit 1 is clear
	for (genvar p = 0; p < GPB_PINS; p++) begin : g_pin
		logic alt_drive;
		if (p < 4) begin : g_btn
			assign alt_drive = 1'b0;
		end else begin : g_axis
			assign alt_drive = axis_discharge[p-4];
		end
		gpb_pin u_pin (
			.clk(clk),
			.resetn(resetn),
			.cfg(cfg_q[p]),
			.gpio_out(dout_q[p]),
			.alt_drive(alt_drive),
			.alt_out(1'b0),
			.pad_in(pad_in[p]),
			.pad_out(pad_out[p]),
			.pad_oe_n(pad_oe_n[p]),
			.level(level[p])
		);
	end

	// Game-port routing; unrouted inputs idle high as if released
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			button_d[i] = cfg_q[i][GPB_ALT_BIT] ?
				level[i] : 1'b1;
			axis_d[i] = cfg_q[i+4][GPB_ALT_BIT] ?
				level[i+4] : 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			button_q <= 4'hf;
			axis_q <= 4'hf;
		end else begin
			button_q <= button_d;
			axis_q <= axis_d;
		end
	end

	assign stick_one_button_one = button_q[0];
	assign stick_one_button_two = button_q[1];
	assign stick_two_button_one = button_q[2];
	assign stick_two_button_two = button_q[3];
	assign stick_one_x_axis_rc = axis_q[0];
	assign stick_one_y_axis_rc = axis_q[1];
	assign stick_two_x_axis_rc = axis_q[2];
	assign stick_two_y_axis_rc = axis_q[3];

endmodule

// file: sim/gpb_bank_sva.sv
// Bus and pad assertions for the GPIO bank
`timescale 1ns/1ps
module gpb_bank_sva #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	// Pads
	input wire logic [7:0] pad_oe_n
);
	import gpb_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	chk_write_answer: assert property (wr_both |=> ##1 s_axi_bvalid)
		else $error("write answer not on time");
	chk_write_refuse: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	chk_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid)
		else $error("write answer repeated");
	chk_read_answer: assert property (rd_take |=> s_axi_rvalid)
		else $error("read answer not on time");
	chk_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	chk_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready
		|=> !s_axi_rvalid)
		else $error("read answer repeated");
	chk_cfg_reserved: assert property (rd_take ##0
		(s_axi_araddr[1:0] == 2'h0 && s_axi_araddr >= 12'h08c &&
		s_axi_araddr <= 12'h0a8) |=> s_axi_rresp == GPB_RESP_OKAY &&
		(s_axi_rdata & 32'hffffff78) == 32'h0)
		else $error("pin register read bad");
	chk_misaligned_rd: assert property (rd_take ##0
		(s_axi_araddr[1:0] != 2'h0) |=> s_axi_rresp == GPB_RESP_SLVERR &&
		s_axi_rdata == 32'h0)
		else $error("misaligned read not refused");
	chk_reset_input: assert property ($rose(resetn) |->
		pad_oe_n == 8'hff)
		else $error("pad driven after reset");
endmodule

// file: sim/gpb_pads.sv
// Pin side: pull-ups and external drivers wired with the bank pads
`timescale 1ns/1ps
module gpb_pads (
	// Bank pad drive
	input wire logic [7:0] pad_out,
	input wire logic [7:0] pad_oe_n,
	// External drivers
	input wire logic [7:0] ext_val,
	input wire logic [7:0] ext_en,
	// Resolved pad level
	output logic [7:0] pad_in
);
	// Game-port lines are pulled up; any low driver wins
	assign pad_in = (pad_oe_n | pad_out) & (~ext_en | ext_val);
endmodule

// file: sim/gpb_bank_test.sv
// Self-checking bench for the GPIO bank pin configuration block
`timescale 1ns/1ps
module gpb_bank_test;
	import gpb_pkg::*;
	logic clk = '0;
	logic resetn = '0;
	logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
	logic s_axi_arvalid = '0, s_axi_rready = '0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0, a;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hf, axis_discharge = '0;
	logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [7:0] pad_in, pad_out, pad_oe_n, ext_val = '0, ext_en = '0, m;
	logic stick_one_button_one, stick_one_button_two;
	logic stick_two_button_one, stick_two_button_two;
	logic stick_one_x_axis_rc, stick_one_y_axis_rc;
	logic stick_two_x_axis_rc, stick_two_y_axis_rc;
	logic [7:0] stk;
	int n_fail = 0;
	int tests_run = 0;
	assign stk = {stick_two_y_axis_rc, stick_two_x_axis_rc,
		stick_one_y_axis_rc, stick_one_x_axis_rc, stick_two_button_two,
		stick_two_button_one, stick_one_button_two, stick_one_button_one};
	gpb_bank #(.ADDR_W(12)) DUT (.*);
	gpb_pads u_pads (.*);
	always #12.5 clk = ~clk;
	task automatic chk(input string nm, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] ad, input logic [7:0] v);
		@(posedge clk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		fork
			begin
				do @(posedge clk); while (!s_axi_awready);
				s_axi_awvalid <= 1'h0;
			end
			begin
				do @(posedge clk); while (!s_axi_wready);
				s_axi_wvalid <= 1'h0;
			end
		join
		do @(posedge clk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [11:0] ad);
		@(posedge clk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge clk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task automatic rdc(input logic [11:0] ad, input logic [31:0] e,
		input logic [1:0] er);
		rd(ad);
		chk("rdata", e, d);
		chk("rresp", 32'(er), 32'(r));
	endtask
	// Pad follows the register one edge after commit
	task automatic pad_chk(input string nm, input logic [1:0] e);
		repeat (2) @(posedge clk);
		chk(nm, 32'(e), 32'({pad_oe_n[0], pad_out[0]}));
	endtask
	task automatic finish_test();
		$display("Checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		finish_test();
	end
	initial begin
		repeat (4) @(posedge clk);
		resetn <= 1'h1;
		@(posedge clk);
		chk("oe_n", 32'hff, 32'(pad_oe_n));
		chk("stick", 32'hff, 32'(stk));
		for (int i = 0; i < 8; i++) begin
			a = 12'h08c + 12'(4 * i);
			rdc(a, 32'h01, GPB_RESP_OKAY);
			wr(a, 8'hff);
			chk("bresp", 32'(GPB_RESP_OKAY), 32'(r));
			rdc(a, 32'h87, GPB_RESP_OKAY);
			wr(a, 8'h01);
		end
		rdc(12'h0ac, 32'h0, GPB_RESP_SLVERR);
		rdc(12'h08d, 32'h0, GPB_RESP_SLVERR);
		wr(12'h0ac, 8'h01);
		chk("bresp", 32'(GPB_RESP_SLVERR), 32'(r));
		// Byte lane 0 off: write answered but nothing stored
		s_axi_wstrb <= 4'h0;
		wr(12'h0a8, 8'h87);
		s_axi_wstrb <= 4'hf;
		chk("bresp", 32'(GPB_RESP_OKAY), 32'(r));
		rdc(12'h0a8, 32'h01, GPB_RESP_OKAY);
		wr(12'h100, 8'h01);
		wr(12'h08c, 8'h00);
		pad_chk("drive", 2'h1);
		wr(12'h08c, 8'h02);
		pad_chk("invert", 2'h0);
		wr(12'h08c, 8'h80);
		repeat (2) @(posedge clk);
		chk("od_high", 32'h1, 32'(pad_oe_n[0]));
		wr(12'h100, 8'h00);
		pad_chk("od_low", 2'h0);
		ext_en <= 8'h02;
		wr(12'h090, 8'h03);
		repeat (4) @(posedge clk);
		rd(12'h104);
		chk("level", 32'h1, 32'(d[1]));
		wr(12'h090, 8'h01);
		repeat (4) @(posedge clk);
		rd(12'h104);
		chk("level", 32'h0, 32'(d[1]));
		wr(12'h104, 8'h00);
		chk("bresp", 32'(GPB_RESP_OKAY), 32'(r));
		ext_en <= 8'hff;
		for (int i = 0; i < 8; i++)
			wr(12'h08c + 12'(4 * i), 8'h05);
		// Walking zero exposes any swap in the pin order
		for (int j = 0; j < 8; j++) begin
			m = ~(8'h01 << j);
			ext_val <= m;
			repeat (6) @(posedge clk);
			chk("stick", 32'(m), 32'(stk));
			chk("oe_n", 32'hff, 32'(pad_oe_n));
		end
		ext_en <= 8'h00;
		for (int j = 0; j < 4; j++) begin
			axis_discharge <= 4'(1 << j);
			m = ~(8'h10 << j);
			repeat (6) @(posedge clk);
			chk("discharge", 32'(m), 32'(pad_oe_n));
			chk("stick", 32'(m), 32'(stk));
		end
		ext_en <= 8'hff;
		ext_val <= 8'h00;
		resetn <= 1'h0;
		repeat (2) @(posedge clk);
		resetn <= 1'h1;
		repeat (6) @(posedge clk);
		chk("stick", 32'hff, 32'(stk));
		chk("oe_n", 32'hff, 32'(pad_oe_n));
		rdc(12'h0a8, 32'h01, GPB_RESP_OKAY);
		finish_test();
	end
endmodule
bind gpb_bank gpb_bank_sva #(.ADDR_W(ADDR_W)) u_sva (.*);
